/* File: rtl/pidmux_pkg.sv */
// Constants for the peripheral identifier and pin multiplexer glue.
// Assumes a 32-pin, three-port chip with a plain register port.
package pidmux_pkg;

    // Peripheral address region and window size
    localparam logic [31:0] PERIPH_BASE = 32'hFFFA_0000;
    localparam logic [31:0] PERIPH_LAST = 32'hFFFC_FFFF;
    localparam int WIN_SHIFT = 14;
    localparam int WIN_W = 4;

    // Identifiers
    localparam int ID_FAST_IRQ = 0;
    localparam int ID_SYS_IRQ = 1;
    localparam int ID_EXT_IRQ_0 = 29;
    localparam int NUM_SYS_SRC = 7;
    localparam int NUM_EXT_IRQ = 3;

    // Ids with no clock gate: 0, 1, 20, 29, 30, 31
    localparam logic [31:0] NO_GATE_MASK = 32'hE010_0003;
    // Ids 2..28 less reserved 15 and 16
    localparam logic [31:0] PERIPH_IRQ_MASK = 32'h1FFE_7FFC;

    // Per-port register offsets, port p at p * 0x40
    localparam logic [5:0] OFS_GPIO_EN = 6'h00;
    localparam logic [5:0] OFS_PERIPH_EN = 6'h04;
    localparam logic [5:0] OFS_PSR = 6'h08;
    localparam logic [5:0] OFS_AB_SEL = 6'h0C;
    localparam logic [5:0] OFS_OUT_DATA = 6'h10;
    localparam logic [5:0] OFS_OUT_EN = 6'h14;
    localparam logic [5:0] OFS_PULL_UP = 6'h18;
    localparam logic [5:0] OFS_PIN_LVL = 6'h1C;

    // Clock gate and interrupt source registers
    localparam logic [7:0] OFS_CLK_SET = 8'hC0;
    localparam logic [7:0] OFS_CLK_CLR = 8'hC4;
    localparam logic [7:0] OFS_CLK_STAT = 8'hC8;
    localparam logic [7:0] OFS_IRQ_STAT = 8'hCC;

    // Index 2 is port C, 0 is port A
    localparam logic [2:0][31:0] PSR_RESET = {32'h0000_0430, 32'h0000_0000, 32'h0000_0000};
    localparam logic [2:0][31:0] A_PRESENT = {32'hFFFF_FFF0, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    localparam logic [2:0][31:0] B_PRESENT = {32'h007F_FFFF, 32'h7FFF_3CCF, 32'hFFC0_0C3B};
    localparam logic [31:0] PULL_UP_RESET = 32'hFFFF_FFFF;

endpackage : pidmux_pkg

/* File: rtl/pidmux_top.sv */
// Peripheral identifier map, interrupt source wiring, clock gates and
// the three-port pin multiplexer. Assumes pads, peripherals and a
// register master on clock_in; pad inputs are asynchronous.
// Function
// - Peripheral registers sit in 0xFFFA0000..0xFFFCFFFF, one 16 KB window each.
// - One identifier indexes both interrupt source and clock gate bit.
// - Ids: 0 fast, 1 system, 2-4 ports, 15-16 reserved, 29-31 external.
// - Clock gate writes for ids 0, 1, 20, 29-31 are ignored.
// - Source 1 is the OR of seven system interrupt lines.
// - System contributor clocks always run; id 1 has no clock gate.
// - Fast and three external inputs have own ids, no clock control.
// - Three port controllers, each up to 32 shared pins.
// - Each pin is general I/O or peripheral function A or B.
// - General I/O pins reset as pulled-up inputs, status bit zero.
// - Function pins reset assigned, pulled up, status bit one.
// - Port C pins 4, 5, 10 reset as upper address outputs.
// - An output signal on two selected pins drives both alike.
`timescale 1ns/1ps

module pidmux_top #(
    parameter int NUM_PORTS = 3,
    parameter int PINS = 32
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Peripheral window decode
    input wire logic [31:0] bus_addr_in,
    output logic win_hit_out,
    output logic [pidmux_pkg::WIN_W-1:0] win_index_out,
    // Interrupt sources
    input wire logic fast_irq_in,
    input wire logic [pidmux_pkg::NUM_EXT_IRQ-1:0] ext_irq_in,
    input wire logic [pidmux_pkg::NUM_SYS_SRC-1:0] sys_irq_in,
    input wire logic [31:0] periph_irq_in,
    output logic [31:0] irq_src_out,
    // Clock gates
    output logic [31:0] periph_clk_en_out,
    output logic sys_clk_en_out,
    // Peripheral side of the pin multiplexer
    input wire logic [PINS-1:0] per_a_data_in [NUM_PORTS],
    input wire logic [PINS-1:0] per_a_oe_in [NUM_PORTS],
    input wire logic [PINS-1:0] per_b_data_in [NUM_PORTS],
    input wire logic [PINS-1:0] per_b_oe_in [NUM_PORTS],
    output logic [PINS-1:0] pin_level_out [NUM_PORTS],
    // Pads
    input wire logic [PINS-1:0] pad_in [NUM_PORTS],
    output logic [PINS-1:0] pad_out [NUM_PORTS],
    output logic [PINS-1:0] pad_oe_out [NUM_PORTS],
    output logic [PINS-1:0] pad_pull_up_out [NUM_PORTS]
);

    generate
        if (NUM_PORTS != 3 || PINS != 32)
        begin : g_bad_size
            $error("pidmux_top serves three ports of 32 pins only");
        end
    endgenerate

    logic [PINS-1:0] psr_q [NUM_PORTS];
    logic [PINS-1:0] absel_q [NUM_PORTS];
    logic [PINS-1:0] odata_q [NUM_PORTS];
    logic [PINS-1:0] oen_q [NUM_PORTS];
    logic [PINS-1:0] pullup_q [NUM_PORTS];
    logic [PINS-1:0] s1_q [NUM_PORTS];
    logic [PINS-1:0] s2_q [NUM_PORTS];
    logic [PINS-1:0] s3_q [NUM_PORTS];
    logic [31:0] clk_en_q;
    logic [3:0] irq_s1_q;
    logic [3:0] irq_s2_q;
    logic [3:0] irq_s3_q;
    logic [3:0] irq_lvl_q;
    logic [31:0] rdata_d;
    logic [31:0] irq_src_d;
    logic [1:0] port_sel;
    logic [5:0] port_ofs;
    logic [31:0] clk_wmask;

    assign port_sel = reg_addr_in[7:6];
    assign port_ofs = reg_addr_in[5:0];
    // Writes to fixed ids never reach the gate bits
    assign clk_wmask = reg_wdata_in & ~pidmux_pkg::NO_GATE_MASK;

    // Window decode, registered
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            win_hit_out <= 1'b0;
            win_index_out <= '0;
        end
        else if (bus_addr_in >= pidmux_pkg::PERIPH_BASE &&
                 bus_addr_in <= pidmux_pkg::PERIPH_LAST)
        begin
            win_hit_out <= 1'b1;
            win_index_out <= pidmux_pkg::WIN_W'((bus_addr_in - pidmux_pkg::PERIPH_BASE)
                                                >> pidmux_pkg::WIN_SHIFT);
        end
        else
        begin
            win_hit_out <= 1'b0;
            win_index_out <= '0;
        end
    end

    // Clock gate bits, bit index equals identifier
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            clk_en_q <= '0;
        end
        else if (reg_wr_in && reg_addr_in == pidmux_pkg::OFS_CLK_SET)
        begin
            clk_en_q <= clk_en_q | clk_wmask;
        end
        else if (reg_wr_in && reg_addr_in == pidmux_pkg::OFS_CLK_CLR)
        begin
            clk_en_q <= clk_en_q & ~clk_wmask;
        end
    end

    assign periph_clk_en_out = clk_en_q;

    // System contributors are never gated
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sys_clk_en_out <= 1'b1;
        end
        else
        begin
            sys_clk_en_out <= 1'b1;
        end
    end

    // Fast and external interrupt pins: three stages, rises on two high samples, falls on one low
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            irq_s1_q <= '0;
            irq_s2_q <= '0;
            irq_s3_q <= '0;
            irq_lvl_q <= '0;
        end
        else
        begin
            irq_s1_q <= {ext_irq_in, fast_irq_in};
            irq_s2_q <= irq_s1_q;
            irq_s3_q <= irq_s2_q;
            irq_lvl_q <= (irq_s2_q & irq_s3_q) | (irq_lvl_q & ~(irq_s2_q ^ irq_s3_q));
        end
    end

    always_comb
    begin
        irq_src_d = periph_irq_in & pidmux_pkg::PERIPH_IRQ_MASK;
        irq_src_d[pidmux_pkg::ID_FAST_IRQ] = irq_lvl_q[0];
        irq_src_d[pidmux_pkg::ID_SYS_IRQ] = |sys_irq_in;
        irq_src_d[pidmux_pkg::ID_EXT_IRQ_0 +: pidmux_pkg::NUM_EXT_IRQ] = irq_lvl_q[3:1];
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            irq_src_out <= '0;
        end
        else
        begin
            irq_src_out <= irq_src_d;
        end
    end

    // Per-port registers, synchronisers and pad drive
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            logic wr_here;
            logic [PINS-1:0] a_en;
            logic [PINS-1:0] b_en;

            assign wr_here = reg_wr_in && port_sel == 2'(p);

            always_ff @(posedge clock_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    psr_q[p] <= pidmux_pkg::PSR_RESET[p];
                end
                else if (wr_here && port_ofs == pidmux_pkg::OFS_GPIO_EN)
                begin
                    psr_q[p] <= psr_q[p] & ~reg_wdata_in;
                end
                else if (wr_here && port_ofs == pidmux_pkg::OFS_PERIPH_EN)
                begin
                    psr_q[p] <= psr_q[p] | reg_wdata_in;
                end
            end

            always_ff @(posedge clock_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    absel_q[p] <= '0;
                    odata_q[p] <= '0;
                    oen_q[p] <= '0;
                    pullup_q[p] <= pidmux_pkg::PULL_UP_RESET;
                end
                else if (wr_here && port_ofs == pidmux_pkg::OFS_AB_SEL)
                begin
                    absel_q[p] <= reg_wdata_in;
                end
                else if (wr_here && port_ofs == pidmux_pkg::OFS_OUT_DATA)
                begin
                    odata_q[p] <= reg_wdata_in;
                end
                else if (wr_here && port_ofs == pidmux_pkg::OFS_OUT_EN)
                begin
                    oen_q[p] <= reg_wdata_in;
                end
                else if (wr_here && port_ofs == pidmux_pkg::OFS_PULL_UP)
                begin
                    pullup_q[p] <= reg_wdata_in;
                end
            end

            // Pads are asynchronous; filter one-sample high glitches before peripherals see them
            always_ff @(posedge clock_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    s1_q[p] <= '0;
                    s2_q[p] <= '0;
                    s3_q[p] <= '0;
                    pin_level_out[p] <= '0;
                end
                else
                begin
                    s1_q[p] <= pad_in[p];
                    s2_q[p] <= s1_q[p];
                    s3_q[p] <= s2_q[p];
                    pin_level_out[p] <= (s2_q[p] & s3_q[p]) |
                                        (pin_level_out[p] & ~(s2_q[p] ^ s3_q[p]));
                end
            end

            // Empty slots never drive; shared outputs drive every selected pin
            assign a_en = ~absel_q[p] & pidmux_pkg::A_PRESENT[p] & per_a_oe_in[p];
            assign b_en = absel_q[p] & pidmux_pkg::B_PRESENT[p] & per_b_oe_in[p];

            always_ff @(posedge clock_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    pad_out[p] <= '0;
                    pad_oe_out[p] <= '0;
                    pad_pull_up_out[p] <= pidmux_pkg::PULL_UP_RESET;
                end
                else
                begin
                    pad_oe_out[p] <= (psr_q[p] & (a_en | b_en)) |
                                     (~psr_q[p] & oen_q[p]);
                    pad_out[p] <= (psr_q[p] & ((a_en & per_a_data_in[p]) |
                                               (b_en & per_b_data_in[p]))) |
                                  (~psr_q[p] & odata_q[p]);
                    pad_pull_up_out[p] <= pullup_q[p];
                end
            end
        end
    endgenerate

    // Register read mux
    always_comb
    begin
        rdata_d = '0;
        if (reg_addr_in == pidmux_pkg::OFS_CLK_STAT)
        begin
            rdata_d = clk_en_q;
        end
        else if (reg_addr_in == pidmux_pkg::OFS_IRQ_STAT)
        begin
            rdata_d = irq_src_out;
        end
        else if (32'(port_sel) < NUM_PORTS && port_ofs == pidmux_pkg::OFS_PSR)
        begin
            rdata_d = psr_q[port_sel];
        end
        else if (32'(port_sel) < NUM_PORTS && port_ofs == pidmux_pkg::OFS_AB_SEL)
        begin
            rdata_d = absel_q[port_sel];
        end
        else if (32'(port_sel) < NUM_PORTS && port_ofs == pidmux_pkg::OFS_OUT_DATA)
        begin
            rdata_d = odata_q[port_sel];
        end
        else if (32'(port_sel) < NUM_PORTS && port_ofs == pidmux_pkg::OFS_OUT_EN)
        begin
            rdata_d = oen_q[port_sel];
        end
        else if (32'(port_sel) < NUM_PORTS && port_ofs == pidmux_pkg::OFS_PULL_UP)
        begin
            rdata_d = pullup_q[port_sel];
        end
        else if (32'(port_sel) < NUM_PORTS && port_ofs == pidmux_pkg::OFS_PIN_LVL)
        begin
            rdata_d = pin_level_out[port_sel];
        end
    end

    // Data held only in the cycle after the strobe
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            reg_rdata_out <= '0;
        end
        else if (reg_rd_in)
        begin
            reg_rdata_out <= rdata_d;
        end
        else
        begin
            reg_rdata_out <= '0;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence fast_pin_high_s;
        fast_irq_in [*4];
    endsequence

    sequence psr_read_s;
        reg_rd_in && reg_addr_in == {2'b10, pidmux_pkg::OFS_PSR};
    endsequence

    AST_WINDOW_DECODE: assert property (
        bus_addr_in == 32'hFFFA_4000 |=> win_hit_out && win_index_out == 4'h1)
        else $error("window decode wrong");

    AST_SAME_ID: assert property (
        reg_wr_in && reg_addr_in == pidmux_pkg::OFS_CLK_SET && reg_wdata_in[5]
        |=> periph_clk_en_out[5])
        else $error("clock gate bit not set at its id");

    AST_RESERVED_QUIET: assert property (
        irq_src_out[16:15] == 2'b00)
        else $error("reserved source active");

    AST_NO_GATE: assert property (
        (periph_clk_en_out & pidmux_pkg::NO_GATE_MASK) == 32'h0000_0000)
        else $error("fixed id gate bit set");

    AST_SYS_OR: assert property (
        1'b1 |=> irq_src_out[1] == (|$past(sys_irq_in)))
        else $error("system source not or of contributors");

    AST_SYS_CLK: assert property (
        sys_clk_en_out && !periph_clk_en_out[1])
        else $error("system clock gated");

    AST_FAST_SYNC: assert property (
        fast_pin_high_s |-> ##2 irq_src_out[0])
        else $error("fast input not seen after filter");

    AST_GPIO_RESET: assert property (
        $rose(reset_n_in) |-> psr_q[0] == 32'h0000_0000 && pad_pull_up_out[1] == '1)
        else $error("general pins not reset as pulled inputs");

    AST_PSR_READ: assert property (
        psr_read_s |=> reg_rdata_out == $past(psr_q[2]))
        else $error("status read mismatch");

    AST_ADDR_RESET: assert property (
        $rose(reset_n_in) |-> psr_q[2][5:4] == 2'b11 && psr_q[2][10])
        else $error("upper address pins not in function after reset");

    AST_EMPTY_SLOT: assert property (
        psr_q[2][0] && !absel_q[2][0] |=> !pad_oe_out[2][0])
        else $error("empty slot drives pin");

endmodule : pidmux_top

/* File: tb/pidmux_top_tb.sv */
// Self-checking bench for the peripheral identifier and pin multiplexer glue.
// Assumes the default three ports of 32 pins; the bench drives every input itself.
`timescale 1ns/1ps

module pidmux_top_tb;
    // Clock, reset and register port
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    // Window decode, interrupts and clock gates
    logic [31:0] bus_addr_in = 32'h0000_0000;
    logic win_hit_out;
    logic [pidmux_pkg::WIN_W-1:0] win_index_out;
    logic fast_irq_in = 1'b0;
    logic [2:0] ext_irq_in = 3'h0;
    logic [6:0] sys_irq_in = 7'h00;
    logic [31:0] periph_irq_in = 32'h0000_0000;
    logic [31:0] irq_src_out;
    logic [31:0] periph_clk_en_out;
    logic sys_clk_en_out;
    // Pin multiplexer
    logic [31:0] pa_d [3];
    logic [31:0] pa_oe [3];
    logic [31:0] pb_d [3];
    logic [31:0] pb_oe [3];
    logic [31:0] lvl [3];
    logic [31:0] pad_i [3];
    logic [31:0] pad_o [3];
    logic [31:0] pad_oe [3];
    logic [31:0] pad_pu [3];
    logic [31:0] seed = 32'h0001_6824;
    int mismatches = 0;
    int checks_done = 0;

    pidmux_top pidmux_top_i (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .bus_addr_in(bus_addr_in), .win_hit_out(win_hit_out),
        .win_index_out(win_index_out), .fast_irq_in(fast_irq_in), .ext_irq_in(ext_irq_in),
        .sys_irq_in(sys_irq_in), .periph_irq_in(periph_irq_in), .irq_src_out(irq_src_out),
        .periph_clk_en_out(periph_clk_en_out), .sys_clk_en_out(sys_clk_en_out),
        .per_a_data_in(pa_d), .per_a_oe_in(pa_oe), .per_b_data_in(pb_d),
        .per_b_oe_in(pb_oe), .pin_level_out(lvl), .pad_in(pad_i), .pad_out(pad_o),
        .pad_oe_out(pad_oe), .pad_pull_up_out(pad_pu)
    );

    initial
    begin
        forever #12.5 clock_in = ~clock_in;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
        return seed;
    endfunction : rnd

    function automatic logic [7:0] addr(input int p, input logic [5:0] ofs);
        return 8'(p * 64) + {2'b00, ofs};
    endfunction : addr

    // Empty slots never drive, whatever the peripheral asks
    function automatic logic [31:0] exp_oe(input int p, input logic [31:0] st, sel, oer);
        return (st & ~sel & pa_oe[p] & pidmux_pkg::A_PRESENT[p])
            | (st & sel & pb_oe[p] & pidmux_pkg::B_PRESENT[p]) | (~st & oer);
    endfunction : exp_oe

    function automatic logic [31:0] exp_out(input int p, input logic [31:0] st, sel, od);
        return (st & ((sel & pb_d[p]) | (~sel & pa_d[p]))) | (~st & od);
    endfunction : exp_out

    function automatic logic [31:0] exp_irq();
        return (periph_irq_in & pidmux_pkg::PERIPH_IRQ_MASK) | {ext_irq_in, 29'h0}
            | {30'h0, |sys_irq_in, fast_irq_in};
    endfunction : exp_irq

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1;
        check(reg_rdata_out, e);
    endtask : rd_chk

    task automatic give_verdict();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (20000) @(posedge clock_in);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        logic [31:0] r, a, e, st [3], sel, od, oer, pu, hit;
        logic [31:0] corner [5];
        corner = '{32'hFFF9_FFFF, 32'hFFFA_0000, 32'hFFFC_FFFF, 32'hFFFD_0000, 32'hFFFA_4000};
        for (int p = 0; p < 3; p++)
        begin
            pa_d[p] = rnd();
            pa_oe[p] = rnd();
            pb_d[p] = rnd();
            pb_oe[p] = rnd();
            pad_i[p] = rnd();
            st[p] = pidmux_pkg::PSR_RESET[p];
        end
        repeat (6) @(posedge clock_in);
        reset_n_in <= 1'b1;
        for (int p = 0; p < 3; p++)
        begin
            rd_chk(addr(p, pidmux_pkg::OFS_PSR), st[p]);
            rd_chk(addr(p, pidmux_pkg::OFS_PULL_UP), 32'hFFFF_FFFF);
            check(pad_pu[p], 32'hFFFF_FFFF);
            check(pad_oe[p], exp_oe(p, st[p], 32'h0, 32'h0));
        end
        check({31'h0, sys_clk_en_out}, 32'h0000_0001);
        // Clock gates: blocked ids never change
        r = rnd();
        wr(pidmux_pkg::OFS_CLK_SET, r);
        rd_chk(pidmux_pkg::OFS_CLK_STAT, r & ~pidmux_pkg::NO_GATE_MASK);
        wr(pidmux_pkg::OFS_CLK_SET, 32'hFFFF_FFFF);
        rd_chk(pidmux_pkg::OFS_CLK_STAT, ~pidmux_pkg::NO_GATE_MASK);
        check(periph_clk_en_out, ~pidmux_pkg::NO_GATE_MASK);
        wr(pidmux_pkg::OFS_CLK_CLR, r);
        rd_chk(pidmux_pkg::OFS_CLK_STAT, ~pidmux_pkg::NO_GATE_MASK & ~r);
        check({31'h0, sys_clk_en_out}, 32'h0000_0001);
        wr(8'hF0, rnd());
        rd_chk(8'hF0, 32'h0000_0000);
        rd_chk(8'h24, 32'h0000_0000);
        // Pins must be held 2 cycles before they count
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clock_in);
            fast_irq_in <= (k == 0);
            ext_irq_in <= (k == 0) ? 3'b101 : 3'b010;
            repeat (8) @(posedge clock_in);
            for (int i = 0; i < 12; i++)
            begin
                @(posedge clock_in);
                r = rnd();
                sys_irq_in <= (i == 0) ? 7'h00 : r[6:0] & r[13:7];
                periph_irq_in <= rnd();
                repeat (2) @(posedge clock_in);
                #1;
                check(irq_src_out, exp_irq());
                rd_chk(pidmux_pkg::OFS_IRQ_STAT, exp_irq());
            end
        end
        for (int i = 0; i < 24; i++)
        begin
            a = (i < 5) ? corner[i] : {12'hFFF, 20'(rnd())};
            hit = (a >= pidmux_pkg::PERIPH_BASE && a <= pidmux_pkg::PERIPH_LAST);
            e = hit ? {27'h0, 1'b1, 4'((a - pidmux_pkg::PERIPH_BASE) >> 14)} : 32'h0;
            @(posedge clock_in);
            bus_addr_in <= a;
            repeat (2) @(posedge clock_in);
            #1;
            check({27'h0, win_hit_out, win_index_out}, e);
        end
        for (int i = 0; i < 12; i++)
        begin
            int p;
            p = i % 3;
            r = rnd();
            wr(addr(p, pidmux_pkg::OFS_PERIPH_EN), r);
            a = rnd() & rnd();
            wr(addr(p, pidmux_pkg::OFS_GPIO_EN), a);
            st[p] = (st[p] | r) & ~a;
            rd_chk(addr(p, pidmux_pkg::OFS_PSR), st[p]);
            sel = rnd();
            od = rnd();
            oer = rnd();
            pu = rnd();
            wr(addr(p, pidmux_pkg::OFS_AB_SEL), sel);
            wr(addr(p, pidmux_pkg::OFS_OUT_DATA), od);
            wr(addr(p, pidmux_pkg::OFS_OUT_EN), oer);
            wr(addr(p, pidmux_pkg::OFS_PULL_UP), pu);
            rd_chk(addr(p, pidmux_pkg::OFS_AB_SEL), sel);
            rd_chk(addr(p, pidmux_pkg::OFS_OUT_DATA), od);
            rd_chk(addr(p, pidmux_pkg::OFS_OUT_EN), oer);
            rd_chk(addr(p, pidmux_pkg::OFS_PULL_UP), pu);
            @(posedge clock_in);
            pa_d[p] <= rnd();
            pa_oe[p] <= rnd();
            pb_d[p] <= rnd();
            pb_oe[p] <= rnd();
            pad_i[p] <= rnd();
            repeat (6) @(posedge clock_in);
            #1;
            e = exp_oe(p, st[p], sel, oer);
            check(pad_oe[p], e);
            check(pad_o[p] & e, exp_out(p, st[p], sel, od) & e);
            check(pad_pu[p], pu);
            check(lvl[p], pad_i[p]);
            rd_chk(addr(p, pidmux_pkg::OFS_PIN_LVL), pad_i[p]);
        end
        give_verdict();
    end
endmodule : pidmux_top_tb
